//--- rtl/tick_if.sv
// Handshake between the watchdog core and its prescaler.
`timescale 1ns/1ps
interface tick_if;
   logic run;
   logic tick;

   // The prescaler produces ticks while the core lets it run.
   modport source (input run, output tick);
   modport sink   (output run, input tick);
endinterface

//--- rtl/watchdog_pkg.sv
// Constants, register map and state codes for the windowed watchdog timer.
// =====================================================================
package watchdog_pkg;

   // =====================================================================
   // Register map, byte addresses on the APB bus.
   localparam int         ADDR_W      = 12;
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] CFG_OFFSET  = 12'h004;
   localparam logic [11:0] STAT_OFFSET = 12'h008;

   // Control register layout and reset value.
   localparam int         ARM_BIT      = 7;
   localparam int         TOP_BIT      = 6;
   localparam logic [7:0] CTRL_RESET   = 8'h7f;
   localparam logic [6:0] TIMEOUT_FROM = 7'h40;

   // Configuration register fields.
   localparam int CFG_TIE_BIT  = 0;
   localparam int CFG_LONG_BIT = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;

   // Status register fields.
   localparam int STAT_STATE_LSB   = 0;
   localparam int STAT_PULSE_BIT   = 3;
   localparam int STAT_HW_BIT      = 4;
   localparam int STAT_HALTOPT_BIT = 5;
   localparam int STAT_ARMED_BIT   = 6;

   // =====================================================================
   // Timing.
   localparam int PRESCALE_DIV   = 16384;
   localparam int CLK_PERIOD_NS  = 50;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_PULSE_CYCLES =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_W         = 4;
   localparam int WAKE_SHORT_CLKS = 256;
   localparam int WAKE_LONG_CLKS  = 4096;
   localparam int WAKE_W          = 12;

   // =====================================================================
   // Power-mode sequencer states.
   typedef enum logic [2:0] {
      ST_RUN       = 3'b000,
      ST_HALT_STEP = 3'b001,
      ST_HALTED    = 3'b010,
      ST_ACTIVE    = 3'b011,
      ST_WAKE      = 3'b100
   } wdg_state_e;

endpackage

//--- rtl/wdg_prescaler.sv
// Prescaler that gives one tick every DIV clocks while run is high and holds its phase otherwise.
`timescale 1ns/1ps
module wdg_prescaler
   import watchdog_pkg::*;
#(
   parameter int DIV = PRESCALE_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   tick_if.source   tk
);

   localparam int          CW   = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   // =====================================================================
   // Phase counter. Nothing but reset clears it, so a counter write
   // lands at an unknown phase and the timeout varies by one step.
   always_comb begin
      cnt_next = cnt_reg;
      if (tk.run) begin
         if (cnt_reg == LAST) begin
            cnt_next = '0;
         end else begin
            cnt_next = cnt_reg + CW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // A tick lasts one cycle, at the end of each full period.
   assign tk.tick = tk.run & (cnt_reg == LAST);

endmodule

//--- rtl/windowed_watchdog_timer.sv
// Windowed watchdog timer with APB register access and halt handling.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module windowed_watchdog_timer
   import watchdog_pkg::*;
#(
   parameter int PRESCALE = PRESCALE_DIV
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              halt_req,
   input  wire logic              ext_irq,
   input  wire logic              osc_irq,
   input  wire logic              hw_option_pin,
   input  wire logic              halt_option_pin,
   output logic                   wdg_reset_n
);

   // =====================================================================
   // Register selection.
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_CFG  = 2'h1;
   localparam logic [1:0] SEL_STAT = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;
   localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(RESET_PULSE_CYCLES);
   localparam logic [WAKE_W-1:0]  WAKE_SHORT = WAKE_W'(WAKE_SHORT_CLKS - 1);
   localparam logic [WAKE_W-1:0]  WAKE_LONG  = WAKE_W'(WAKE_LONG_CLKS - 1);

   function automatic logic [1:0] decode_reg(input logic [ADDR_W-1:0] a);
      if (a == CTRL_OFFSET) begin
         decode_reg = SEL_CTRL;
      end else if (a == CFG_OFFSET) begin
         decode_reg = SEL_CFG;
      end else if (a == STAT_OFFSET) begin
         decode_reg = SEL_STAT;
      end else begin
         decode_reg = SEL_NONE;
      end
   endfunction

   logic                hw_sync1_reg;
   logic                hw_sync2_reg;
   logic                ho_sync1_reg;
   logic                ho_sync2_reg;
   logic [1:0]          cfg_reg;
   logic [1:0]          cfg_next;
   logic [31:0]         prdata_reg;
   logic [31:0]         prdata_next;
   logic                arm_reg;
   logic                arm_next;
   logic [6:0]          count_reg;
   logic [6:0]          count_next;
   wdg_state_e          state_reg;
   wdg_state_e          state_next;
   logic [WAKE_W-1:0]   wake_reg;
   logic [WAKE_W-1:0]   wake_next;
   logic [PULSE_W-1:0]  pulse_reg;
   logic [PULSE_W-1:0]  pulse_next;
   logic                rst_n_reg;
   logic                rst_n_next;
   logic [1:0]          sel;
   logic                setup;
   logic                access;
   logic                wr_ctrl;
   logic                wr_cfg;
   logic                armed;
   logic                counting;
   logic                fire;
   logic                tie;

   tick_if tk ();

   // =====================================================================
   // Option straps come from outside the clock domain, so each passes two
   // flip-flops; only the second stage is read by the logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hw_sync1_reg <= 1'b0;
         hw_sync2_reg <= 1'b0;
         ho_sync1_reg <= 1'b0;
         ho_sync2_reg <= 1'b0;
      end else begin
         hw_sync1_reg <= hw_option_pin;
         hw_sync2_reg <= hw_sync1_reg;
         ho_sync1_reg <= halt_option_pin;
         ho_sync2_reg <= ho_sync1_reg;
      end
   end

   // =====================================================================
   // APB slave: zero wait states, read data captured in the setup phase.
   assign sel     = decode_reg(paddr);
   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign wr_ctrl = access & pwrite & pstrb[0] & (sel == SEL_CTRL);
   assign wr_cfg  = access & pwrite & pstrb[0] & (sel == SEL_CFG);
   assign pready  = 1'b1;
   // Unmapped addresses and writes to the status word are refused.
   assign pslverr = access & ((sel == SEL_NONE) | (pwrite & (sel == SEL_STAT)));
   assign tie     = cfg_reg[CFG_TIE_BIT];

   // Next configuration and read data.
   always_comb begin
      cfg_next    = cfg_reg;
      prdata_next = prdata_reg;
      if (wr_cfg) begin
         cfg_next = pwdata[1:0];
      end
      if (setup) begin
         prdata_next = '0;
         if (sel == SEL_CTRL) begin
            prdata_next[7:0] = {arm_reg, count_reg};
         end else if (sel == SEL_CFG) begin
            prdata_next[1:0] = cfg_reg;
         end else if (sel == SEL_STAT) begin
            prdata_next[STAT_STATE_LSB +: 3] = state_reg;
            prdata_next[STAT_PULSE_BIT]      = ~rst_n_reg;
            prdata_next[STAT_HW_BIT]         = hw_sync2_reg;
            prdata_next[STAT_HALTOPT_BIT]    = ho_sync2_reg;
            prdata_next[STAT_ARMED_BIT]      = armed;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg    <= CFG_RESET;
         prdata_reg <= '0;
      end else begin
         cfg_reg    <= cfg_next;
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;

   // =====================================================================
   // Watchdog core. The hardware option overrides the software arm bit.
   assign armed    = arm_reg | hw_sync2_reg;
   // Slow and wait modes are not seen here at all, so they count as run.
   assign counting = (state_reg == ST_RUN) | (state_reg == ST_HALT_STEP);
   assign tk.run   = counting;

   wdg_prescaler #(
      .DIV (PRESCALE)
   ) u_prescaler (
      .pclk    (pclk),
      .presetn (presetn),
      .tk      (tk)
   );

   // Next counter, arm bit, sequencer state and wake delay.
   always_comb begin
      count_next = count_reg;
      arm_next   = arm_reg;
      state_next = state_reg;
      wake_next  = wake_reg;
      fire       = 1'b0;
      if (counting && tk.tick) begin
         count_next = count_reg - 7'h01;
         if (armed && count_reg == TIMEOUT_FROM) begin
            fire = 1'b1;
         end
      end
      case (state_reg)
         ST_RUN: begin
            if (halt_req) begin
               if (tie) begin
                  state_next = ST_ACTIVE;
               end else if (ho_sync2_reg && armed) begin
                  fire = 1'b1;
               end else begin
                  state_next = ST_HALT_STEP;
               end
            end
         end
         ST_HALT_STEP: begin
            // One last decrement, then the counter stops until ext_irq wakes it.
            if (tk.tick) begin
               state_next = ST_HALTED;
            end
         end
         ST_HALTED: begin
            if (ext_irq) begin
               state_next = ST_WAKE;
               wake_next  = cfg_reg[CFG_LONG_BIT] ? WAKE_LONG : WAKE_SHORT;
            end
         end
         ST_ACTIVE: begin
            if (osc_irq || ext_irq) begin
               state_next = ST_RUN;
            end
         end
         ST_WAKE: begin
            if (wake_reg == '0) begin
               state_next = ST_RUN;
            end else begin
               wake_next = wake_reg - WAKE_W'(1);
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
      // A write reloads the counter and never touches the prescaler.
      if (wr_ctrl) begin
         count_next = pwdata[6:0];
         if (pwdata[ARM_BIT]) begin
            arm_next = 1'b1;
         end
         if ((pwdata[ARM_BIT] || hw_sync2_reg) && !pwdata[TOP_BIT]) begin
            fire = 1'b1;
         end
      end
   end

   // Reset disarms and restarts through the short wake delay.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_reg   <= CTRL_RESET[ARM_BIT];
         count_reg <= CTRL_RESET[6:0];
         state_reg <= ST_WAKE;
         wake_reg  <= WAKE_SHORT;
      end else begin
         arm_reg   <= arm_next;
         count_reg <= count_next;
         state_reg <= state_next;
         wake_reg  <= wake_next;
      end
   end

   // =====================================================================
   // Reset pulse stretcher. A new cause restarts the full pulse width.
   always_comb begin
      pulse_next = pulse_reg;
      if (fire) begin
         pulse_next = PULSE_LOAD;
      end else if (pulse_reg != '0) begin
         pulse_next = pulse_reg - PULSE_W'(1);
      end
      rst_n_next = (pulse_next == '0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_reg <= '0;
         rst_n_reg <= 1'b1;
      end else begin
         pulse_reg <= pulse_next;
         rst_n_reg <= rst_n_next;
      end
   end

   assign wdg_reset_n = rst_n_reg;

   // =====================================================================
   // Checks.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   decrement_step_a:
      assert property (counting && tk.tick && !wr_ctrl
                       |=> count_reg == $past(count_reg) - 7'h01)
      else $error("counter did not step down on a tick");

   timeout_reset_a:
      assert property (armed && counting && tk.tick && count_reg == TIMEOUT_FROM
                       |=> !wdg_reset_n)
      else $error("timeout wrap gave no reset");

   pulse_width_a:
      assert property ($fell(wdg_reset_n)
                       |-> !wdg_reset_n[*8] ##1 !wdg_reset_n ##1 !wdg_reset_n)
      else $error("reset pulse is shorter than ten cycles");

   // A new cause inside the pulse legally stretches it, so only a quiet pulse must end.
   pulse_end_a:
      assert property ($fell(wdg_reset_n) ##0 !fire[*8] ##1 !fire[*2] |=> wdg_reset_n)
      else $error("reset pulse outlasts ten cycles without a new cause");

   arm_sticky_a:
      assert property (arm_reg |=> arm_reg)
      else $error("arm bit cleared without reset");

   soft_reset_a:
      assert property (wr_ctrl && pwdata[ARM_BIT] && !pwdata[TOP_BIT] |=> !wdg_reset_n)
      else $error("software reset write gave no reset");

   halt_reset_a:
      assert property (state_reg == ST_RUN && halt_req && !tie && ho_sync2_reg && armed
                       |=> !wdg_reset_n && state_reg == ST_RUN)
      else $error("armed halt gave no reset");

   halt_frozen_a:
      assert property (state_reg == ST_HALTED && !wr_ctrl
                       |=> $stable(count_reg) && rst_n_reg)
      else $error("counter moved or reset fired while halted");

   wake_delay_a:
      assert property (state_reg == ST_HALTED && ext_irq && !cfg_reg[CFG_LONG_BIT]
                       |=> state_reg == ST_WAKE ##256 state_reg == ST_RUN)
      else $error("short wake delay is not 256 cycles");

   active_wake_a:
      assert property (state_reg == ST_ACTIVE && (osc_irq || ext_irq)
                       |=> state_reg == ST_RUN)
      else $error("active halt did not resume at once");

   hw_armed_a:
      assert property (hw_sync2_reg |-> armed)
      else $error("hardware option did not arm the watchdog");

endmodule

//--- tb/tb_windowed_watchdog_timer.sv
// Self-checking testbench for the windowed watchdog timer.
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
   import watchdog_pkg::*;

   // =====================================================================
   // Signals and design instance
   localparam int PS = 16;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [31:0]       pwdata = '0;
   logic [3:0]        pstrb = 4'hf;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              halt_req = 1'b0;
   logic              ext_irq = 1'b0;
   logic              osc_irq = 1'b0;
   logic              hw_option_pin = 1'b0;
   logic              halt_option_pin = 1'b0;
   logic              wdg_reset_n;
   int                failures = 0;
   int                cmp_count = 0;

   windowed_watchdog_timer #(.PRESCALE(PS)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_req(halt_req), .ext_irq(ext_irq), .osc_irq(osc_irq),
      .hw_option_pin(hw_option_pin), .halt_option_pin(halt_option_pin),
      .wdg_reset_n(wdg_reset_n));

   // A 50 ns clock for the 20 MHz bus.
   always #25 pclk = ~pclk;

   // =====================================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic        e;
      apb(a, 1'b1, d, v, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      logic e;
      apb(a, 1'b0, 32'h0, v, e);
   endtask

   // One-cycle pulse on halt_req (0), ext_irq (1) or osc_irq (2).
   task automatic pulse(input int k);
      @(posedge pclk);
      if (k == 0) halt_req <= 1'b1;
      else if (k == 1) ext_irq <= 1'b1;
      else osc_irq <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      ext_irq <= 1'b0;
      osc_irq <= 1'b0;
   endtask

   // Expects a reset pulse to start within [lo,hi) cycles, then checks its width.
   task automatic expect_pulse(input int lo, input int hi);
      int n;
      int w;
      n = 0;
      w = 0;
      while (wdg_reset_n !== 1'b0 && n < hi) begin
         @(negedge pclk);
         n++;
      end
      chk(n >= lo && n < hi, 1);
      while (wdg_reset_n === 1'b0 && w < 64) begin
         @(negedge pclk);
         w++;
      end
      chk(w, RESET_PULSE_CYCLES);
   endtask

   // System reset with the straps set, then an optional settling wait.
   task automatic sys_reset(input logic hw, input logic ho, input int settle);
      @(posedge pclk);
      presetn <= 1'b0;
      hw_option_pin <= hw;
      halt_option_pin <= ho;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (settle) @(posedge pclk);
   endtask

   // =====================================================================
   // Scenarios
   task automatic t_reset;
      logic [31:0] v;
      logic        e;
      rd(CTRL_OFFSET, v);
      chk(v, 32'h7f);
      rd(CFG_OFFSET, v);
      chk(v, 32'h0);
      rd(STAT_OFFSET, v);
      chk(v[2:0], 3'h4);
      apb(12'h00c, 1'b0, 32'h0, v, e);
      chk(v, 32'h0);
      chk(e, 1'b1);
      apb(STAT_OFFSET, 1'b1, 32'h0, v, e);
      chk(e, 1'b1);
      // A write with byte lane 0 disabled must leave the register alone.
      pstrb <= 4'h0;
      wr(CFG_OFFSET, 32'h1);
      pstrb <= 4'hf;
      rd(CFG_OFFSET, v);
      chk(v, 32'h0);
      $display("test reset done");
   endtask

   // Unarmed counter still steps exactly once per PS cycles.
   task automatic t_free;
      logic [31:0] c1;
      logic [31:0] c2;
      rd(CTRL_OFFSET, c1);
      // The two capture edges sit exactly four prescaler periods apart.
      repeat (4 * PS - 3) @(posedge pclk);
      rd(CTRL_OFFSET, c2);
      chk((c1 - c2) & 32'h7f, 32'h4);
      wr(CTRL_OFFSET, 32'h00);
      repeat (3) @(negedge pclk);
      chk(wdg_reset_n, 1'b1);
      $display("test free running done");
   endtask

   task automatic t_sw;
      logic [31:0] v;
      wr(CTRL_OFFSET, 32'h80);
      expect_pulse(0, 4);
      sys_reset(1'b0, 1'b0, 300);
      rd(CTRL_OFFSET, v);
      chk(v[7], 1'b0);
      $display("test software reset done");
   endtask

   // Refreshes hold the reset off; a write without the arm bit cannot disarm.
   task automatic t_timeout;
      logic [31:0] v;
      wr(CTRL_OFFSET, 32'hff);
      wr(CTRL_OFFSET, 32'h7f);
      rd(CTRL_OFFSET, v);
      chk(v[7], 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_OFFSET, 32'hc2);
         repeat (PS) @(negedge pclk);
         chk(wdg_reset_n, 1'b1);
      end
      wr(CTRL_OFFSET, 32'hc1);
      expect_pulse(PS - 4, 2 * PS + 4);
      sys_reset(1'b0, 1'b0, 300);
      $display("test timeout done");
   endtask

   // Active halt freezes the counter; either interrupt resumes at once.
   task automatic t_active;
      logic [31:0] c1;
      logic [31:0] c2;
      wr(CFG_OFFSET, 32'h1);
      for (int k = 2; k > 0; k--) begin
         pulse(0);
         rd(STAT_OFFSET, c1);
         chk(c1[2:0], 3'h3);
         rd(CTRL_OFFSET, c1);
         repeat (3 * PS) @(posedge pclk);
         rd(CTRL_OFFSET, c2);
         chk(c2, c1);
         pulse(k);
         rd(STAT_OFFSET, c1);
         chk(c1[2:0], 3'h0);
      end
      wr(CFG_OFFSET, 32'h0);
      $display("test active halt done");
   endtask

   task automatic t_halt_reset;
      logic [31:0] v;
      sys_reset(1'b0, 1'b1, 300);
      rd(STAT_OFFSET, v);
      chk(v[5], 1'b1);
      wr(CTRL_OFFSET, 32'hff);
      pulse(0);
      expect_pulse(0, 4);
      sys_reset(1'b0, 1'b0, 300);
      $display("test halt reset done");
   endtask

   // Plain halt steps once then stops; ext_irq wakes it after 256 cycles.
   task automatic t_halt_step;
      logic [31:0] v;
      // The write lands one edge before a prescaler tick, so the halt starts at c1.
      wr(CTRL_OFFSET, 32'hc2);
      pulse(0);
      repeat (4 * PS) @(negedge pclk);
      chk(wdg_reset_n, 1'b1);
      rd(STAT_OFFSET, v);
      chk(v[2:0], 3'h2);
      rd(CTRL_OFFSET, v);
      chk(v, 32'hc0);
      pulse(1);
      rd(STAT_OFFSET, v);
      chk(v[2:0], 3'h4);
      repeat (240) @(posedge pclk);
      rd(STAT_OFFSET, v);
      chk(v[2:0], 3'h4);
      repeat (20) @(posedge pclk);
      rd(STAT_OFFSET, v);
      chk(v[2:0], 3'h0);
      expect_pulse(0, PS + 4);
      sys_reset(1'b0, 1'b0, 300);
      rd(CTRL_OFFSET, v);
      chk(v[7], 1'b0);
      $display("test halt step done");
   endtask

   // The hardware option arms the block without any software write.
   task automatic t_hw;
      logic [31:0] v;
      sys_reset(1'b1, 1'b0, 300);
      rd(STAT_OFFSET, v);
      chk({v[6], v[4]}, 2'h3);
      expect_pulse(50 * PS, 70 * PS);
      sys_reset(1'b0, 1'b0, 300);
      $display("test hardware option done");
   endtask

   // =====================================================================
   // Verdict, main sequence and watchdog
   task automatic final_report;
      $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      sys_reset(1'b0, 1'b0, 0);
      t_reset();
      repeat (300) @(posedge pclk);
      t_free();
      t_sw();
      t_timeout();
      t_active();
      t_halt_reset();
      t_halt_step();
      t_hw();
      final_report();
   end

   // Cuts a hang short well past the expected run length.
   initial begin
      #(20000 * 50);
      failures++;
      final_report();
   end
endmodule
